// ---- design/adc_pkg.sv ----
package adc_pkg;
  // device register offsets on the host bus
  localparam logic [3:0] ADC_OFS_PACER_LO = 4'h0;
  localparam logic [3:0] ADC_OFS_PACER_HI = 4'h1;
  localparam logic [3:0] ADC_OFS_RES_LO = 4'h4;
  localparam logic [3:0] ADC_OFS_RES_HI = 4'h5;
  localparam logic [3:0] ADC_OFS_DAC_LO = 4'h4;
  localparam logic [3:0] ADC_OFS_DAC_HI = 4'h5;
  localparam logic [3:0] ADC_OFS_DAC_STEP = 4'h2;
  localparam logic [3:0] ADC_OFS_GAIN = 4'h9;
  localparam logic [3:0] ADC_OFS_TRIG = 4'ha;
  localparam logic [3:0] ADC_OFS_MODE = 4'hb;
  localparam logic [3:0] ADC_OFS_CHAN = 4'hc;
  localparam int ADC_DAC_NUM = 2;
  // high result byte layout
  localparam int ADC_READY_BIT = 4;
  // mode control values
  localparam logic [2:0] ADC_MODE_OFF = 3'h0;
  localparam logic [2:0] ADC_MODE_SWPOLL = 3'h1;
  localparam logic [2:0] ADC_MODE_DMA = 3'h2;
  localparam logic [2:0] ADC_MODE_INT = 3'h6;
  // values after reset
  localparam logic [2:0] ADC_MODE_RST = ADC_MODE_OFF;
  localparam logic [15:0] ADC_PACER_RST = 16'h0000;
  localparam logic ADC_READY_RST = 1'b1;
  // controller command registers
  localparam logic [2:0] ADC_H_CTRL = 3'h0;
  localparam logic [2:0] ADC_H_CONV = 3'h1;
  localparam logic [2:0] ADC_H_DAC = 3'h2;
  localparam logic [2:0] ADC_H_RAW = 3'h3;
  localparam logic [2:0] ADC_H_STAT = 3'h4;
  localparam logic [2:0] ADC_H_RES = 3'h5;
  localparam logic [2:0] ADC_H_DMA = 3'h6;
  localparam int ADC_H_GO_CONV = 0;
  localparam int ADC_H_GO_DAC = 1;
  localparam int ADC_H_DAC_SEL = 12;
  localparam int ADC_H_ST_BUSY = 0;
  localparam int ADC_H_ST_DONE = 1;
  localparam int ADC_H_ST_DMA = 2;
  // timing
  localparam int ADC_CLK_PERIOD_PS = 4000;
  localparam int ADC_SETTLE_TIME_US = 10;
  localparam int ADC_SETTLE_CYC =
    (ADC_SETTLE_TIME_US * 1000000 + ADC_CLK_PERIOD_PS - 1) / ADC_CLK_PERIOD_PS;
endpackage

// ---- design/adc_bus_if.sv ----
`timescale 1ns/10ps
interface adc_bus_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic dmaReq;
  logic dmaAck;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    input dmaAck,
    output rdata,
    output irq,
    output dmaReq
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    output dmaAck,
    input rdata,
    input irq,
    input dmaReq
  );
endinterface

// ---- design/adc_device.sv ----
`timescale 1ns/10ps
module adc_device
  import adc_pkg::*;
#(
  parameter int PACER_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  adc_bus_if.dev bus,
  input wire logic extTrigPin,
  input wire logic extTrigSel,
  output logic adcStart,
  output logic [3:0] adcChannel,
  output logic [2:0] adcGain,
  input wire logic adcDone,
  input wire logic [11:0] adcData,
  output logic [11:0] dac0Code,
  output logic [11:0] dac1Code
);

  // pacer divisor is written as two bytes
  if (PACER_W < 9 || PACER_W > 16) begin : gPacerCheck
    $error("PACER_W must lie between 9 and 16");
  end

  typedef struct packed {
    logic [1:0] trigSync;
    logic trigPrev;
    logic [1:0] selSync;
    logic [2:0] mode;
    logic [3:0] chan;
    logic [2:0] gain;
    logic [PACER_W-1:0] pacerDiv;
    logic [PACER_W-1:0] pacerCnt;
    logic busy;
    logic ready;
    logic [11:0] result;
    logic start;
    logic irq;
    logic dmaReq;
    logic [7:0] rdata;
    logic [ADC_DAC_NUM-1:0][7:0] dacLow;
    logic [ADC_DAC_NUM-1:0][11:0] dacCode;
  } adc_dev_state_t;

  localparam adc_dev_state_t DEV_RST = '{
    mode: ADC_MODE_RST,
    pacerDiv: PACER_W'(ADC_PACER_RST),
    ready: ADC_READY_RST,
    default: '0
  };

  adc_dev_state_t state;
  adc_dev_state_t next_state;
  logic internalSel;
  logic pacedMode;
  logic extEdge;
  logic swTrig;
  logic pacerTick;
  logic extTrig;

  // trigger source qualification
  always_comb begin
    internalSel = ~state.selSync[1];
    pacedMode = (state.mode == ADC_MODE_DMA) || (state.mode == ADC_MODE_INT);
    extEdge = state.trigSync[1] & ~state.trigPrev;
    swTrig = bus.wr && (bus.addr == ADC_OFS_TRIG) &&
             (state.mode == ADC_MODE_SWPOLL) && internalSel;
    pacerTick = pacedMode && internalSel && (state.pacerDiv != '0) &&
                (state.pacerCnt == '0);
    extTrig = extEdge && pacedMode && !internalSel;
  end

  // next state of the whole block
  always_comb begin
    next_state = state;
    next_state.trigSync = {state.trigSync[0], extTrigPin};
    next_state.trigPrev = state.trigSync[1];
    next_state.selSync = {state.selSync[0], extTrigSel};
    next_state.start = 1'b0;
    next_state.rdata = 8'h00;

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        ADC_OFS_PACER_LO: next_state.pacerDiv[7:0] = bus.wdata;
        ADC_OFS_PACER_HI: next_state.pacerDiv[PACER_W-1:8] = bus.wdata[PACER_W-9:0];
        ADC_OFS_GAIN: next_state.gain = bus.wdata[2:0];
        ADC_OFS_MODE: next_state.mode = bus.wdata[2:0];
        ADC_OFS_CHAN: next_state.chan = bus.wdata[3:0];
        default: begin
        end
      endcase
    end

    // double-buffered dac latches, one pair of bytes per channel
    for (int i = 0; i < ADC_DAC_NUM; i++) begin
      if (bus.wr && bus.addr == 4'(ADC_OFS_DAC_LO + ADC_OFS_DAC_STEP * i)) begin
        next_state.dacLow[i] = bus.wdata;
      end
      if (bus.wr && bus.addr == 4'(ADC_OFS_DAC_HI + ADC_OFS_DAC_STEP * i)) begin
        next_state.dacCode[i] = {bus.wdata[3:0], state.dacLow[i]};
      end
    end

    // pacer timer reloads from the divisor on every tick
    if (pacedMode && internalSel && state.pacerDiv != '0) begin
      if (state.pacerCnt == '0) begin
        next_state.pacerCnt = state.pacerDiv - PACER_W'(1);
      end else begin
        next_state.pacerCnt = state.pacerCnt - PACER_W'(1);
      end
    end else begin
      next_state.pacerCnt = state.pacerDiv - PACER_W'(1);
    end

    // acknowledge clears, placed before sets so a new event wins
    if (bus.rd && bus.addr == ADC_OFS_RES_HI) begin
      next_state.irq = 1'b0;
    end
    if (bus.dmaAck) begin
      next_state.dmaReq = 1'b0;
    end

    // start a conversion only when idle
    if ((swTrig || pacerTick || extTrig) && !state.busy) begin
      next_state.start = 1'b1;
      next_state.busy = 1'b1;
      next_state.ready = 1'b1;
    end

    // latch the result and report completion
    if (state.busy && adcDone) begin
      next_state.busy = 1'b0;
      next_state.result = adcData;
      next_state.ready = 1'b0;
      if (state.mode == ADC_MODE_INT) begin
        next_state.irq = 1'b1;
      end
      if (state.mode == ADC_MODE_DMA) begin
        next_state.dmaReq = 1'b1;
      end
    end

    // read data stands one cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        ADC_OFS_RES_LO: next_state.rdata = state.result[7:0];
        ADC_OFS_RES_HI: begin
          next_state.rdata[3:0] = state.result[11:8];
          next_state.rdata[ADC_READY_BIT] = state.ready;
        end
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= DEV_RST;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from state
  assign bus.rdata = state.rdata;
  assign bus.irq = state.irq;
  assign bus.dmaReq = state.dmaReq;
  assign adcStart = state.start;
  assign adcChannel = state.chan;
  assign adcGain = state.gain;
  assign dac0Code = state.dacCode[0];
  assign dac1Code = state.dacCode[1];

endmodule

// ---- design/adc_host.sv ----
`timescale 1ns/10ps
module adc_host
  import adc_pkg::*;
#(
  parameter int SETTLE_CYCLES = ADC_SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  adc_bus_if.host bus,
  input wire logic [2:0] cmdAddr,
  input wire logic [15:0] cmdWdata,
  input wire logic cmdWr,
  input wire logic cmdRd,
  output logic [15:0] cmdRdata
);

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : gSettleCheck
    $error("SETTLE_CYCLES must lie between 1 and 65535");
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'b0000,
    H_CHAN = 4'b0001,
    H_GAIN = 4'b0010,
    H_SETTLE = 4'b0011,
    H_TRIG = 4'b0100,
    H_PWAIT = 4'b0101,
    H_PCHK = 4'b0110,
    H_LWAIT = 4'b0111,
    H_LCHK = 4'b1000,
    H_DACHI = 4'b1001,
    H_XLWAIT = 4'b1010,
    H_XLCHK = 4'b1011,
    H_XHWAIT = 4'b1100,
    H_XHCHK = 4'b1101,
    H_XACK = 4'b1110
  } adc_host_fsm_t;

  typedef struct packed {
    adc_host_fsm_t fsm;
    logic [15:0] cnt;
    logic goConv;
    logic goDac;
    logic goRaw;
    logic [3:0] chan;
    logic [2:0] gain;
    logic [12:0] dac;
    logic [11:0] raw;
    logic [3:0] hiNib;
    logic [11:0] result;
    logic [11:0] sample;
    logic done;
    logic dmaValid;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic ack;
    logic [15:0] cmdRdata;
  } adc_host_state_t;

  adc_host_state_t state;
  adc_host_state_t next_state;

  // controller sequencing and command registers
  always_comb begin
    next_state = state;
    next_state.wr = 1'b0;
    next_state.rd = 1'b0;
    next_state.ack = 1'b0;
    next_state.cmdRdata = 16'h0000;

    // command reads, result reads clear the sticky flags
    if (cmdRd) begin
      case (cmdAddr)
        ADC_H_STAT: begin
          next_state.cmdRdata[ADC_H_ST_BUSY] = (state.fsm != H_IDLE) ||
            state.goConv || state.goDac || state.goRaw;
          next_state.cmdRdata[ADC_H_ST_DONE] = state.done;
          next_state.cmdRdata[ADC_H_ST_DMA] = state.dmaValid;
        end
        ADC_H_RES: begin
          next_state.cmdRdata = {4'h0, state.result};
          next_state.done = 1'b0;
        end
        ADC_H_DMA: begin
          next_state.cmdRdata = {4'h0, state.sample};
          next_state.dmaValid = 1'b0;
        end
        default: next_state.cmdRdata = 16'h0000;
      endcase
    end

    // command writes post pending jobs
    if (cmdWr) begin
      case (cmdAddr)
        ADC_H_CTRL: begin
          next_state.goConv = state.goConv | cmdWdata[ADC_H_GO_CONV];
          next_state.goDac = state.goDac | cmdWdata[ADC_H_GO_DAC];
        end
        ADC_H_CONV: begin
          next_state.chan = cmdWdata[3:0];
          next_state.gain = cmdWdata[6:4];
        end
        ADC_H_DAC: next_state.dac = cmdWdata[12:0];
        ADC_H_RAW: begin
          next_state.raw = cmdWdata[11:0];
          next_state.goRaw = 1'b1;
        end
        default: begin
        end
      endcase
    end

    case (state.fsm)
      H_IDLE: begin
        if (bus.dmaReq) begin
          next_state.rd = 1'b1;
          next_state.addr = ADC_OFS_RES_LO;
          next_state.fsm = H_XLWAIT;
        end else if (state.goConv) begin
          // a request posted in this very cycle stays pending
          next_state.goConv = cmdWr && (cmdAddr == ADC_H_CTRL) && cmdWdata[ADC_H_GO_CONV];
          next_state.wr = 1'b1;
          next_state.addr = ADC_OFS_MODE;
          next_state.wdata = {5'h00, ADC_MODE_SWPOLL};
          next_state.fsm = H_CHAN;
        end else if (state.goDac) begin
          next_state.goDac = cmdWr && (cmdAddr == ADC_H_CTRL) && cmdWdata[ADC_H_GO_DAC];
          next_state.wr = 1'b1;
          next_state.addr = 4'(ADC_OFS_DAC_LO + ADC_OFS_DAC_STEP * state.dac[ADC_H_DAC_SEL]);
          next_state.wdata = state.dac[7:0];
          next_state.fsm = H_DACHI;
        end else if (state.goRaw) begin
          next_state.goRaw = cmdWr && (cmdAddr == ADC_H_RAW);
          next_state.wr = 1'b1;
          next_state.addr = state.raw[11:8];
          next_state.wdata = state.raw[7:0];
        end
      end
      H_CHAN: begin
        next_state.wr = 1'b1;
        next_state.addr = ADC_OFS_CHAN;
        next_state.wdata = {4'h0, state.chan};
        next_state.fsm = H_GAIN;
      end
      H_GAIN: begin
        next_state.wr = 1'b1;
        next_state.addr = ADC_OFS_GAIN;
        next_state.wdata = {5'h00, state.gain};
        next_state.cnt = 16'(SETTLE_CYCLES);
        next_state.fsm = H_SETTLE;
      end
      H_SETTLE: begin
        if (state.cnt <= 16'h0001) begin
          next_state.wr = 1'b1;
          next_state.addr = ADC_OFS_TRIG;
          next_state.wdata = 8'h00;
          next_state.fsm = H_TRIG;
        end else begin
          next_state.cnt = state.cnt - 16'h0001;
        end
      end
      H_TRIG, H_PCHK: begin
        if (state.fsm == H_PCHK && !bus.rdata[ADC_READY_BIT]) begin
          next_state.hiNib = bus.rdata[3:0];
          next_state.rd = 1'b1;
          next_state.addr = ADC_OFS_RES_LO;
          next_state.fsm = H_LWAIT;
        end else begin
          next_state.rd = 1'b1;
          next_state.addr = ADC_OFS_RES_HI;
          next_state.fsm = H_PWAIT;
        end
      end
      H_PWAIT: next_state.fsm = H_PCHK;
      H_LWAIT: next_state.fsm = H_LCHK;
      H_LCHK: begin
        next_state.result = {state.hiNib, bus.rdata};
        next_state.done = 1'b1;
        next_state.fsm = H_IDLE;
      end
      H_DACHI: begin
        next_state.wr = 1'b1;
        next_state.addr = 4'(ADC_OFS_DAC_HI + ADC_OFS_DAC_STEP * state.dac[ADC_H_DAC_SEL]);
        next_state.wdata = {4'h0, state.dac[11:8]};
        next_state.fsm = H_IDLE;
      end
      H_XLWAIT: next_state.fsm = H_XLCHK;
      H_XLCHK: begin
        next_state.sample[7:0] = bus.rdata;
        next_state.rd = 1'b1;
        next_state.addr = ADC_OFS_RES_HI;
        next_state.fsm = H_XHWAIT;
      end
      H_XHWAIT: next_state.fsm = H_XHCHK;
      H_XHCHK: begin
        next_state.sample[11:8] = bus.rdata[3:0];
        next_state.dmaValid = 1'b1;
        next_state.ack = 1'b1;
        next_state.fsm = H_XACK;
      end
      H_XACK: next_state.fsm = H_IDLE;
      default: next_state.fsm = H_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bus.addr = state.addr;
  assign bus.wdata = state.wdata;
  assign bus.wr = state.wr;
  assign bus.rd = state.rd;
  assign bus.dmaAck = state.ack;
  assign cmdRdata = state.cmdRdata;

endmodule

// ---- tb/adc_checker.sv ----
`timescale 1ns/10ps
module adc_checker
  import adc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic dmaReq,
  input wire logic dmaAck
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] modeReg;
  // mode value last written over the bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeReg <= ADC_MODE_RST;
    end else if (wr && addr == ADC_OFS_MODE) begin
      modeReg <= wdata[2:0];
    end
  end
  a_strobe_excl: assert property (!(wr && rd))
    else $error("read and write strobes together");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_ready_layout: assert property ($past(rd && addr == ADC_OFS_RES_HI) |-> rdata[7:5] == 3'h0)
    else $error("high result byte has stray bits");
  a_irq_mode: assert property ($rose(irq) |-> modeReg == ADC_MODE_INT)
    else $error("interrupt outside interrupt mode");
  a_dma_mode: assert property ($rose(dmaReq) |-> modeReg == ADC_MODE_DMA)
    else $error("dma request outside dma mode");
  a_irq_hold: assert property (irq && !(rd && addr == ADC_OFS_RES_HI) |=> irq)
    else $error("interrupt dropped without read");
  a_dma_hold: assert property (dmaReq && !dmaAck |=> dmaReq)
    else $error("dma request dropped without ack");
  a_ack_pair: assert property (dmaAck |-> dmaReq)
    else $error("ack without request");
  a_dma_serve: assert property ($rose(dmaReq) |-> ##[1:200] dmaAck)
    else $error("dma request not served");
  // main traffic seen
  c_irq: cover property ($rose(irq));
  c_ack: cover property (dmaAck);
  c_poll: cover property (rd && addr == ADC_OFS_RES_HI);
endmodule

// ---- tb/adc_dac_conversion_control_tb.sv ----
`timescale 1ns/10ps
module adc_dac_conversion_control_tb;
  import adc_pkg::*;
  localparam int CONV = 40;
  localparam int PACE = 100;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic extTrigPin = 1'b0;
  logic extTrigSel = 1'b0;
  logic adcStart;
  logic adcDone = 1'b0;
  logic [3:0] adcChannel;
  logic [2:0] adcGain;
  logic [11:0] adcData = 12'h000;
  logic [11:0] dac0Code;
  logic [11:0] dac1Code;
  logic [2:0] cmdAddr = 3'h0;
  logic [15:0] cmdWdata = 16'h0000;
  logic cmdWr = 1'b0;
  logic cmdRd = 1'b0;
  logic [15:0] cmdRdata;
  logic [6:0] seenCh;
  logic [15:0] d;
  logic [11:0] resQ[$];
  int fail_count = 0;
  int tests_run = 0;
  int starts = 0;
  int left = 0;
  int cyc = 0;
  int lastStart = 0;
  bit pace = 0;
  adc_bus_if bus();
  always #2 core_clk = ~core_clk;
  adc_device u_adc_device (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
    .extTrigPin(extTrigPin), .extTrigSel(extTrigSel), .adcStart(adcStart),
    .adcChannel(adcChannel), .adcGain(adcGain), .adcDone(adcDone), .adcData(adcData),
    .dac0Code(dac0Code), .dac1Code(dac1Code));
  adc_host #(.SETTLE_CYCLES(4)) u_adc_host (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd),
    .cmdRdata(cmdRdata));
  adc_checker u_adc_checker (.core_clk(core_clk), .rst_b(rst_b), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .irq(bus.irq),
    .dmaReq(bus.dmaReq), .dmaAck(bus.dmaAck));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // converter stand-in: answers each start after CONV cycles with a fresh sample
  always @(posedge core_clk) begin
    cyc++;
    if (adcStart) begin
      starts++;
      seenCh = {adcGain, adcChannel};
      if (pace && lastStart != 0) chk("pacer gap", 16'(PACE), 16'(cyc - lastStart));
      lastStart = cyc;
      left = CONV;
      adcDone <= 1'b0;
    end else if (left == 1) begin
      // last cycle of the conversion: hand over a fresh sample
      left = 0;
      resQ.push_back(12'($urandom));
      adcData <= resQ[$];
      adcDone <= 1'b1;
    end else begin
      if (left > 0) left--;
      adcDone <= 1'b0;
    end
  end
  // command port bus cycles
  task automatic cw(input logic [2:0] a, input logic [15:0] v);
    @(posedge core_clk);
    cmdAddr <= a;
    cmdWdata <= v;
    cmdWr <= 1'b1;
    @(posedge core_clk);
    cmdWr <= 1'b0;
  endtask
  task automatic cr(input logic [2:0] a);
    @(posedge core_clk);
    cmdAddr <= a;
    cmdRd <= 1'b1;
    @(posedge core_clk);
    cmdRd <= 1'b0;
    #1 d = cmdRdata;
  endtask
  task automatic rw(input logic [3:0] a, input logic [7:0] v);
    cw(ADC_H_RAW, {4'h0, a, v});
    repeat (8) @(posedge core_clk);
  endtask
  task automatic waitBit(input int b);
    for (int k = 0; k < 500; k++) begin
      cr(ADC_H_STAT);
      if (d[b] === 1'b1) return;
    end
    fail_count++;
    $display("mismatch status bit %0d expected 1 seen 0", b);
    tally_and_finish();
  endtask
  task automatic pulse(input int h);
    @(posedge core_clk);
    extTrigPin <= 1'b1;
    repeat (h) @(posedge core_clk);
    extTrigPin <= 1'b0;
  endtask
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask
  function automatic logic [11:0] dacOut(input int n);
    return (n != 0) ? dac1Code : dac0Code;
  endfunction
  initial begin
    logic [3:0] ch;
    logic [2:0] g;
    logic [11:0] v;
    logic [7:0] h;
    int s0;
    void'($urandom(25));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    cr(ADC_H_STAT);
    chk("status", 16'h0000, d);
    fin("reset");
    // polled software conversions on random channels and gains
    for (int i = 0; i < 4; i++) begin
      ch = 4'($urandom);
      g = 3'($urandom);
      cw(ADC_H_CONV, {9'h000, g, ch});
      cw(ADC_H_CTRL, 16'h0001);
      waitBit(ADC_H_ST_DONE);
      cr(ADC_H_RES);
      chk("result", resQ[$], d[11:0]);
      chk("channel", {9'h000, g, ch}, {9'h000, seenCh});
    end
    rw(ADC_OFS_CHAN, {4'hf, ch});
    chk("mux", {12'h000, ch}, {12'h000, adcChannel});
    fin("polling");
    // double-buffered output latches
    for (int n = 0; n < ADC_DAC_NUM; n++) begin
      v = 12'($urandom);
      h = 8'($urandom);
      cw(ADC_H_DAC, {3'h0, 1'(n), v});
      cw(ADC_H_CTRL, 16'h0002);
      repeat (20) @(posedge core_clk);
      chk("dac", v, dacOut(n));
      rw(ADC_OFS_DAC_HI + 4'(n) * ADC_OFS_DAC_STEP, h);
      chk("dac high", {h[3:0], v[7:0]}, dacOut(n));
      rw(ADC_OFS_DAC_LO + 4'(n) * ADC_OFS_DAC_STEP, ~v[7:0]);
      chk("dac low", {h[3:0], v[7:0]}, dacOut(n));
    end
    fin("dac");
    // external edges with dma, second edge lands while busy
    rw(ADC_OFS_MODE, {5'h00, ADC_MODE_DMA});
    extTrigSel <= 1'b1;
    s0 = starts;
    for (int i = 0; i < 2; i++) begin
      pulse(10);
      repeat (3) @(posedge core_clk);
      pulse(5);
      waitBit(ADC_H_ST_DMA);
      chk("starts", 16'(s0 + i + 1), 16'(starts));
      cr(ADC_H_DMA);
      chk("dma sample", resQ[$], d[11:0]);
    end
    fin("dma");
    // interrupt on completion
    rw(ADC_OFS_MODE, {5'h00, ADC_MODE_INT});
    pulse(4);
    for (int k = 0; k < 200 && bus.irq !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("irq", 16'h0001, {15'h0000, bus.irq});
    chk("dma req", 16'h0000, {15'h0000, bus.dmaReq});
    fin("interrupt");
    // pacer programmed with mode off, where it stays idle, then paced dma
    extTrigSel <= 1'b0;
    rw(ADC_OFS_MODE, {5'h00, ADC_MODE_OFF});
    rw(ADC_OFS_PACER_LO, 8'(PACE));
    rw(ADC_OFS_PACER_HI, 8'h00);
    s0 = starts;
    repeat (300) @(posedge core_clk);
    chk("idle starts", 16'(s0), 16'(starts));
    rw(ADC_OFS_MODE, {5'h00, ADC_MODE_DMA});
    lastStart = 0;
    pace = 1;
    s0 = starts;
    repeat (1000) @(posedge core_clk);
    pace = 0;
    chk("pacer runs", 16'h0001, {15'h0000, (starts - s0) >= 9});
    chk("irq cleared", 16'h0000, {15'h0000, bus.irq});
    rw(ADC_OFS_PACER_LO, 8'h00);
    fin("pacer");
    tally_and_finish();
  end
endmodule
